//--- core/pelr_pkg.sv
// constants of the phy event interrupt and rx latency control block
//
// Behaviour
// - latency select 1 gives variable rx latency, never dropping a preamble nibble.
// - latency select 0 (reset) gives fixed latency; first packet may lose one nibble.
// - after one nibble is dropped, no further drop until the next link-up.
// - jabber enable bit lets a jabber event raise the interrupt.
// - parallel detect fault enable bit gates that event; read-write, resets to 0.
// - link partner acknowledge enable bit gates that event; read-write, resets to 0.
// - link down enable bit gates that event; read-write, resets to 0.
// - remote fault enable bit gates that event; read-write, resets to 0.
// - link up enable bit gates that event; read-write, resets to 0.
// - jabber flag is read-only, self-clearing, set on jabber, resets to 0.
// - receive error flag is read-only, self-clearing, set on error, resets to 0.
// - page receive flag is read-only, self-clearing, set on page, resets to 0.
// - parallel detect fault flag is read-only, self-clearing, resets to 0.
// - link partner acknowledge flag is read-only, self-clearing, resets to 0.
// - link down flag is read-only, self-clearing, set on link loss, resets 0.
// - remote fault flag is read-only, self-clearing, set on fault, resets to 0.
// - link up flag is read-only, self-clearing, set on link up, resets 0.
`default_nettype none
package pelr_pkg;
    localparam int REG_AW = 5;
    localparam int DW = 16;
    localparam int N_EVT = 8;
    localparam int PHY_AW = 5;
    localparam int CNT_W = 5;
    // register addresses
    localparam logic [4:0] REG_EXP_CTRL = 5'h18;
    localparam logic [4:0] REG_INT_CS = 5'h1B;
    // expanded control fields
    localparam logic [15:0] EXP_CTRL_RESET = 16'h0801;
    localparam int EXP_VAR_LAT_BIT = 10;
    localparam int EXP_PRE10_BIT = 6;
    // interrupt control/status fields
    localparam int INT_EN_LSB = 8;
    localparam logic [7:0] INT_EN_RESET = 8'h00;
    localparam logic [7:0] INT_FLAG_RESET = 8'h00;
    localparam int EVT_LINK_UP = 0;
    // management frame fields
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [4:0] HDR_LAST = 5'h0C;
    localparam logic [4:0] WR_LAST = 5'h11;
    localparam logic [4:0] RD_LAST = 5'h10;
    localparam int HDR_START_BIT = 12;
    localparam int HDR_OP_MSB = 11;
    localparam int HDR_OP_LSB = 10;
    localparam int HDR_PHY_MSB = 9;
    localparam int HDR_PHY_LSB = 5;
    localparam logic [4:0] CNT_ONE = 5'h01;
    localparam logic [4:0] CNT_ZERO = 5'h00;
    typedef enum logic [4:0] {
        ST_HUNT = 5'b00001,
        ST_HDR = 5'b00010,
        ST_TA = 5'b00100,
        ST_RDAT = 5'b01000,
        ST_WDAT = 5'b10000
    } pelr_state_t;
endpackage
`default_nettype wire

//--- core/pelr_reg_if.sv
// register access carrier between the management slave and the register file
`default_nettype none
interface pelr_reg_if;
    logic [pelr_pkg::REG_AW-1:0] addr;
    logic wr;
    logic rd;
    logic [pelr_pkg::DW-1:0] wdata;
    logic [pelr_pkg::DW-1:0] rdata;
    modport slave (output addr, output wr, output rd, output wdata, input rdata);
    modport regs (input addr, input wr, input rd, input wdata, output rdata);
endinterface
`default_nettype wire

//--- core/pelr_mdio_slave.sv
// serial management frame slave, clocked on the core clock
`default_nettype none
module pelr_mdio_slave (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic mdc_in,
    input wire logic mdio_in,
    input wire logic [pelr_pkg::PHY_AW-1:0] phy_addr_in,
    output logic mdio_out,
    output logic mdio_oe_out,
    pelr_reg_if.slave bus
);
    logic mdc_s1;
    logic mdc_s2;
    logic mdc_prev;
    logic mdio_s1;
    logic mdio_s2;
    logic rise;
    logic [11:0] hdr;
    logic [12:0] full;
    logic [4:0] cnt;
    logic [15:0] sh;
    pelr_pkg::pelr_state_t state;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mdc_s1 <= 1'b0;
            mdc_s2 <= 1'b0;
            mdc_prev <= 1'b0;
            mdio_s1 <= 1'b1;
            mdio_s2 <= 1'b1;
        end else if (ce_in) begin
            mdc_s1 <= mdc_in;
            mdc_s2 <= mdc_s1;
            mdc_prev <= mdc_s2;
            mdio_s1 <= mdio_in;
            mdio_s2 <= mdio_s1;
        end
    end

    assign rise = mdc_s2 & ~mdc_prev;
    assign full = {hdr, mdio_s2};

    // ----------------------------------------
    // frame sequencer
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= pelr_pkg::ST_HUNT;
            hdr <= 12'h000;
            cnt <= pelr_pkg::CNT_ZERO;
            sh <= 16'h0000;
            mdio_out <= 1'b0;
            mdio_oe_out <= 1'b0;
            bus.addr <= 5'h00;
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            bus.wdata <= 16'h0000;
        end else if (ce_in) begin
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            if (bus.rd) begin
                sh <= bus.rdata;
            end
            if (rise) begin
                case (state)
                    pelr_pkg::ST_HUNT: begin
                        if (!mdio_s2) begin
                            state <= pelr_pkg::ST_HDR;
                            cnt <= pelr_pkg::CNT_ZERO;
                        end
                    end
                    pelr_pkg::ST_HDR: begin
                        hdr <= full[11:0];
                        cnt <= cnt + pelr_pkg::CNT_ONE;
                        if (cnt == pelr_pkg::HDR_LAST) begin
                            cnt <= pelr_pkg::CNT_ZERO;
                            bus.addr <= full[4:0];
                            state <= pelr_pkg::ST_HUNT;
                            if (full[pelr_pkg::HDR_START_BIT]
                                && full[pelr_pkg::HDR_PHY_MSB:pelr_pkg::HDR_PHY_LSB] == phy_addr_in) begin
                                if (full[pelr_pkg::HDR_OP_MSB:pelr_pkg::HDR_OP_LSB] == pelr_pkg::OP_READ) begin
                                    state <= pelr_pkg::ST_TA;
                                    bus.rd <= 1'b1;
                                end else if (full[pelr_pkg::HDR_OP_MSB:pelr_pkg::HDR_OP_LSB] == pelr_pkg::OP_WRITE) begin
                                    state <= pelr_pkg::ST_WDAT;
                                end
                            end
                        end
                    end
                    pelr_pkg::ST_TA: begin
                        mdio_oe_out <= 1'b1;
                        mdio_out <= 1'b0;
                        state <= pelr_pkg::ST_RDAT;
                    end
                    pelr_pkg::ST_RDAT: begin
                        cnt <= cnt + pelr_pkg::CNT_ONE;
                        mdio_out <= sh[15];
                        sh <= {sh[14:0], 1'b0};
                        if (cnt == pelr_pkg::RD_LAST) begin
                            mdio_oe_out <= 1'b0;
                            mdio_out <= 1'b0;
                            state <= pelr_pkg::ST_HUNT;
                        end
                    end
                    pelr_pkg::ST_WDAT: begin
                        cnt <= cnt + pelr_pkg::CNT_ONE;
                        sh <= {sh[14:0], mdio_s2};
                        if (cnt == pelr_pkg::WR_LAST) begin
                            bus.wdata <= {sh[14:0], mdio_s2};
                            bus.wr <= 1'b1;
                            state <= pelr_pkg::ST_HUNT;
                        end
                    end
                    default: begin
                        state <= pelr_pkg::ST_HUNT;
                        mdio_oe_out <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- core/pelr_top.sv
// phy event interrupt and rx latency control, top level
`default_nettype none
module pelr_top (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic mdc_in,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_out,
    input wire logic [pelr_pkg::PHY_AW-1:0] phy_addr_in,
    input wire logic jabber_evt_in,
    input wire logic rx_err_evt_in,
    input wire logic page_rx_evt_in,
    input wire logic pd_fault_evt_in,
    input wire logic lp_ack_evt_in,
    input wire logic link_down_evt_in,
    input wire logic remote_fault_evt_in,
    input wire logic link_up_evt_in,
    input wire logic rx_sof_in,
    input wire logic rx_slip_in,
    output logic var_latency_out,
    output logic pre10_en_out,
    output logic drop_nibble_out,
    output logic irq_out
);
    pelr_reg_if bus ();
    logic [15:0] exp_ctrl;
    logic [7:0] int_en;
    logic [7:0] int_flag;
    logic [7:0] evt;
    logic [7:0] next_flag;
    logic [4:0] addr_s1;
    logic [4:0] addr_s2;
    logic armed;
    logic int_rd;

    // ----------------------------------------
    // strap synchroniser
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            addr_s1 <= 5'h00;
            addr_s2 <= 5'h00;
        end else if (ce_in) begin
            addr_s1 <= phy_addr_in;
            addr_s2 <= addr_s1;
        end
    end

    pelr_mdio_slave u_mdio (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .mdc_in(mdc_in),
        .mdio_in(mdio_in),
        .phy_addr_in(addr_s2),
        .mdio_out(mdio_out),
        .mdio_oe_out(mdio_oe_out),
        .bus(bus.slave)
    );

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            exp_ctrl <= pelr_pkg::EXP_CTRL_RESET;
            int_en <= pelr_pkg::INT_EN_RESET;
        end else if (ce_in && bus.wr) begin
            if (bus.addr == pelr_pkg::REG_EXP_CTRL) begin
                exp_ctrl <= bus.wdata;
            end
            if (bus.addr == pelr_pkg::REG_INT_CS) begin
                int_en <= bus.wdata[15:pelr_pkg::INT_EN_LSB];
            end
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb begin
        bus.rdata = 16'h0000;
        if (bus.addr == pelr_pkg::REG_EXP_CTRL) begin
            bus.rdata = exp_ctrl;
        end else if (bus.addr == pelr_pkg::REG_INT_CS) begin
            bus.rdata = {int_en, int_flag};
        end
    end

    // ----------------------------------------
    // event flags
    // ----------------------------------------
    assign evt[7] = jabber_evt_in;
    assign evt[6] = rx_err_evt_in;
    assign evt[5] = page_rx_evt_in;
    assign evt[4] = pd_fault_evt_in;
    assign evt[3] = lp_ack_evt_in;
    assign evt[2] = link_down_evt_in;
    assign evt[1] = remote_fault_evt_in;
    assign evt[0] = link_up_evt_in;
    assign int_rd = bus.rd && (bus.addr == pelr_pkg::REG_INT_CS);

    always_comb begin
        next_flag = int_flag;
        if (int_rd) begin
            next_flag = 8'h00;
        end
        next_flag = next_flag | evt;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            int_flag <= pelr_pkg::INT_FLAG_RESET;
        end else if (ce_in) begin
            int_flag <= next_flag;
        end
    end

    // ----------------------------------------
    // interrupt output
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else if (ce_in) begin
            irq_out <= |(next_flag & int_en);
        end
    end

    // ----------------------------------------
    // rx latency and preamble control
    // ----------------------------------------
    assign var_latency_out = exp_ctrl[pelr_pkg::EXP_VAR_LAT_BIT];
    assign pre10_en_out = exp_ctrl[pelr_pkg::EXP_PRE10_BIT];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            armed <= 1'b0;
        end else if (ce_in) begin
            if (evt[pelr_pkg::EVT_LINK_UP]) begin
                armed <= 1'b1;
            end else if (rx_sof_in) begin
                armed <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            drop_nibble_out <= 1'b0;
        end else if (ce_in) begin
            drop_nibble_out <= armed && rx_sof_in && rx_slip_in
                && !exp_ctrl[pelr_pkg::EXP_VAR_LAT_BIT];
        end
    end
endmodule
`default_nettype wire

//--- sim/pelr_top_asserts.sv
// port checker of the pelr top
`default_nettype none
module pelr_top_asserts (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic mdc_in,
    input wire logic jabber_evt_in,
    input wire logic rx_err_evt_in,
    input wire logic page_rx_evt_in,
    input wire logic pd_fault_evt_in,
    input wire logic lp_ack_evt_in,
    input wire logic link_down_evt_in,
    input wire logic remote_fault_evt_in,
    input wire logic link_up_evt_in,
    input wire logic rx_sof_in,
    input wire logic rx_slip_in,
    input wire logic var_latency_out,
    input wire logic pre10_en_out,
    input wire logic drop_nibble_out,
    input wire logic irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic armed;
    logic ev_seen;
    logic mdc_q;
    logic [3:0] quiet;
    // ----------------------------------------
    // helper state
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) armed <= 1'b0;
        else if (link_up_evt_in) armed <= 1'b1;
        else if (rx_sof_in) armed <= 1'b0;
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) ev_seen <= 1'b0;
        else if (jabber_evt_in | rx_err_evt_in | page_rx_evt_in | pd_fault_evt_in | lp_ack_evt_in
                 | link_down_evt_in | remote_fault_evt_in | link_up_evt_in) ev_seen <= 1'b1;
    end
    always_ff @(posedge clk_in) begin
        mdc_q <= mdc_in;
        if (mdc_in != mdc_q) quiet <= 4'h0;
        else if (quiet != 4'hF) quiet <= quiet + 4'h1;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence slip_sof;
        rx_sof_in && rx_slip_in;
    endsequence
    sequence one_pulse;
        drop_nibble_out ##1 !drop_nibble_out;
    endsequence
    reset_vals_a: assert property (
        $fell(rst_in) |-> !irq_out && !drop_nibble_out && !var_latency_out && !pre10_en_out)
        else $error("outputs not cleared by reset");
    var_no_drop_a: assert property (
        var_latency_out && $past(var_latency_out) |-> !drop_nibble_out) else $error("drop in variable mode");
    drop_cause_a: assert property (
        drop_nibble_out |-> $past(rx_sof_in && rx_slip_in && armed && !var_latency_out))
        else $error("drop without cause");
    must_drop_a: assert property (
        armed && !var_latency_out && !link_up_evt_in ##0 slip_sof |=> one_pulse) else $error("drop missing");
    single_drop_a: assert property (
        drop_nibble_out |=> !drop_nibble_out) else $error("drop longer than one cycle");
    irq_cause_a: assert property (
        irq_out |-> ev_seen) else $error("irq without event");
    irq_fall_a: assert property (
        $fell(irq_out) |-> quiet < 4'h8) else $error("irq fell without access");
    lat_write_a: assert property (
        $changed(var_latency_out) |-> quiet < 4'h8) else $error("latency bit changed alone");
    pre_write_a: assert property (
        $changed(pre10_en_out) |-> quiet < 4'h8) else $error("preamble bit changed alone");
endmodule
bind pelr_top pelr_top_asserts u_pelr_top_asserts (.clk_in, .rst_in, .mdc_in, .jabber_evt_in, .rx_err_evt_in,
    .page_rx_evt_in, .pd_fault_evt_in, .lp_ack_evt_in, .link_down_evt_in, .remote_fault_evt_in, .link_up_evt_in,
    .rx_sof_in, .rx_slip_in, .var_latency_out, .pre10_en_out, .drop_nibble_out, .irq_out);
`default_nettype wire

//--- sim/pelr_mgmt_host.sv
// station manager model driving management frames
`default_nettype none
module pelr_mgmt_host (
    input wire logic clk_in,
    input wire logic mdio_in,
    input wire logic [4:0] phy_addr_in,
    output logic mdc_out,
    output logic mdio_out,
    output logic mdio_oe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        mdc_out = 1'b0;
        mdio_out = 1'b1;
        mdio_oe_out = 1'b0;
    end
    // ----------------------------------------
    // one frame, idle bits, header, turnaround, data
    // ----------------------------------------
    task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
        logic [33:0] bits;
        bits = {4'b1101, op, phy_addr_in, ra, 2'b10, wd};
        rd = 16'h0000;
        for (int j = 0; j < 34; j++) begin
            @(posedge clk_in);
            mdc_out <= 1'b0;
            mdio_out <= bits[33-j];
            mdio_oe_out <= (op == pelr_pkg::OP_WRITE) || (j < 16);
            repeat (8) @(posedge clk_in);
            if (j > 17) rd[33-j] = mdio_in;
            mdc_out <= 1'b1;
            repeat (7) @(posedge clk_in);
        end
        @(posedge clk_in);
        mdc_out <= 1'b0;
        mdio_oe_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench of the pelr top
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] evt = 8'h00;
    logic sof = 1'b0;
    logic slip = 1'b0;
    logic ce = 1'b1;
    logic mdc, h_out, h_oe, d_out, d_oe, mdio, var_lat, pre10, drop, irq;
    logic [15:0] rd;
    logic [16:0] rows [10];
    int err_count = 0;
    int n_tests = 0;
    always #2.5 clk_in = ~clk_in;
    assign mdio = d_oe ? d_out : (h_oe ? h_out : 1'b1);
    pelr_top u_pelr_top (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .mdc_in(mdc), .mdio_in(mdio),
        .mdio_out(d_out), .mdio_oe_out(d_oe), .phy_addr_in(5'h03), .jabber_evt_in(evt[7]), .rx_err_evt_in(evt[6]),
        .page_rx_evt_in(evt[5]), .pd_fault_evt_in(evt[4]), .lp_ack_evt_in(evt[3]), .link_down_evt_in(evt[2]),
        .remote_fault_evt_in(evt[1]), .link_up_evt_in(evt[0]), .rx_sof_in(sof), .rx_slip_in(slip),
        .var_latency_out(var_lat), .pre10_en_out(pre10), .drop_nibble_out(drop), .irq_out(irq));
    pelr_mgmt_host u_pelr_mgmt_host (.clk_in(clk_in), .mdio_in(mdio), .phy_addr_in(5'h03), .mdc_out(mdc),
        .mdio_out(h_out), .mdio_oe_out(h_oe));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic rd_reg(input logic [4:0] ra);
        u_pelr_mgmt_host.frame(pelr_pkg::OP_READ, ra, 16'h0000, rd);
    endtask
    task automatic wr_reg(input logic [4:0] ra, input logic [15:0] wd);
        u_pelr_mgmt_host.frame(pelr_pkg::OP_WRITE, ra, wd, rd);
    endtask
    task automatic pulse(input logic [7:0] e, input logic s, input logic p);
        @(posedge clk_in);
        evt <= e;
        sof <= s;
        slip <= p;
        @(posedge clk_in);
        evt <= 8'h00;
        sof <= 1'b0;
        slip <= 1'b0;
        #1;
    endtask
    task automatic do_reset();
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
    endtask
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk_in);
        err_count++;
        $display("wrong value at %0t: watchdog expired", $time);
        finish_test();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rows = '{{8'h80, 8'h80, 1'b1}, {8'h40, 8'h40, 1'b1}, {8'h20, 8'hDF, 1'b0}, {8'h20, 8'h20, 1'b1},
                 {8'h10, 8'h10, 1'b1}, {8'h10, 8'hEF, 1'b0}, {8'h08, 8'h08, 1'b1}, {8'h04, 8'hFB, 1'b0},
                 {8'h02, 8'h02, 1'b1}, {8'h01, 8'hFE, 1'b0}};
        do_reset();
        cmp_bit(var_lat, 1'b0);
        rd_reg(5'h18);
        cmp_word(rd, 16'h0801);
        rd_reg(5'h1B);
        cmp_word(rd, 16'h0000);
        $display("reset values done");
        foreach (rows[i]) begin
            wr_reg(5'h1B, {rows[i][8:1], 8'hFF});
            pulse(rows[i][16:9], 1'b0, 1'b0);
            cmp_bit(irq, rows[i][0]);
            rd_reg(5'h1B);
            cmp_word(rd, {rows[i][8:1], rows[i][16:9]});
            cmp_bit(irq, 1'b0);
            rd_reg(5'h1B);
            cmp_word(rd, {rows[i][8:1], 8'h00});
        end
        $display("event rows done");
        pulse(8'h01, 1'b0, 1'b0);
        pulse(8'h00, 1'b1, 1'b1);
        cmp_bit(drop, 1'b1);
        pulse(8'h00, 1'b1, 1'b1);
        cmp_bit(drop, 1'b0);
        pulse(8'h01, 1'b0, 1'b0);
        pulse(8'h00, 1'b1, 1'b0);
        pulse(8'h00, 1'b1, 1'b1);
        cmp_bit(drop, 1'b0);
        $display("fixed latency done");
        wr_reg(5'h18, 16'hFFFF);
        cmp_bit(pre10, 1'b1);
        rd_reg(5'h18);
        cmp_word(rd, 16'hFFFF);
        cmp_bit(var_lat, 1'b1);
        u_pelr_mgmt_host.frame(2'b11, 5'h18, 16'h0000, rd);
        cmp_word(rd, 16'hFFFF);
        rd_reg(5'h18);
        cmp_word(rd, 16'hFFFF);
        pulse(8'h01, 1'b0, 1'b0);
        pulse(8'h00, 1'b1, 1'b1);
        cmp_bit(drop, 1'b0);
        wr_reg(5'h05, 16'hFFFF);
        rd_reg(5'h05);
        cmp_word(rd, 16'h0000);
        $display("variable latency done");
        @(posedge clk_in);
        ce <= 1'b0;
        pulse(8'h80, 1'b0, 1'b0);
        @(posedge clk_in);
        ce <= 1'b1;
        cmp_bit(irq, 1'b0);
        rd_reg(5'h1B);
        cmp_word(rd, 16'hFE01);
        $display("clock enable done");
        do_reset();
        cmp_bit(pre10, 1'b0);
        rd_reg(5'h18);
        cmp_word(rd, 16'h0801);
        rd_reg(5'h1B);
        cmp_word(rd, 16'h0000);
        $display("second reset done");
        finish_test();
    end
endmodule
`default_nettype wire
